// ---- design/erp_receive_path.sv ----
// Ethernet receive path: framing, filtering, CRC check, delay line, FIFO, status
// Notes on behaviour
// - Bytes pass a four-byte delay line so CRC bytes are checked, never stored.
// - A small FIFO decouples receive logic from the buffer controller.
// - Packet rejected and overflow flagged when free space cannot hold it.
// - Host read of an empty receive buffer flags a bus read error.
// - Short packet, CRC error and alignment error are detected and flagged.
// - Data sampled on rising recovered clock edge; clock may stop when idle.
// - Reception starts on carrier only while the link section is enabled.
// - Transmit defers to carrier unless the defer override is high.
// - Pattern 1011 ends preamble; the next bit starts the destination address.
// - Carrier stays up through the frame; its drop ends the frame.
// - Destination tested against two-bit filter mode and multicast hash table.
// - Filtered packets stored only if error-free, unless bad packets accepted.
// - Storing updates header, clears buffer-empty, sets arrived flag, interrupts when enabled.
// - Rejected packets are signalled for discard with a one-cycle pkt_discard pulse.
// - Flawed packets kept for diagnostics carry errors in header status byte.
// - Carrier state is visible as the medium busy flag.
// - Transmit-done flag set when a started transmission finishes.
// - Four-bit collision tally counts collisions, cleared at each packet start.
// - Overflow, CRC, alignment and short errors each interrupt when enabled.
// - Stored packets survive overflow; reception resumes when space frees.
`timescale 1ns/1ps

module erp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr;
  logic [AW:0]      rptr;
  logic             full;
  logic             empty;

  assign empty     = (wptr == rptr);
  assign full      = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = mem[rptr[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (in_valid && !full) begin
      mem[wptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (in_valid && !full) begin
        wptr <= wptr + 1'b1;
      end
      if (out_ready && !empty) begin
        rptr <= rptr + 1'b1;
      end
    end
  end
endmodule : erp_fifo

module erp_receive_path
  import erp_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  // Decoder side
  input  wire logic         rx_clk_rec,
  input  wire logic         rx_line_pos,
  input  wire logic         carrier_present,
  // Configuration
  input  wire logic         link_section_off,
  input  wire logic         filter_mode_high,
  input  wire logic         filter_mode_low,
  input  wire logic         accept_bad,
  input  wire logic [47:0]  station_addr,
  input  wire logic [63:0]  hash_table,
  input  wire logic         defer_override,
  input  wire logic [15:0]  free_space,
  // Buffer controller data path
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [7:0]        out_data,
  output logic              pkt_commit,
  output logic              pkt_discard,
  output erp_hdr_t          pkt_header,
  // Host side
  input  wire logic         host_rd,
  input  wire logic         host_release,
  output logic              rx_buf_empty,
  output erp_rx_stat_t      rx_status,
  input  wire erp_rx_stat_t rx_status_clr,
  input  wire erp_rx_stat_t rx_irq_enable,
  output logic              rx_irq,
  // Transmit statistics
  input  wire logic         tx_start,
  input  wire logic         tx_finish,
  input  wire logic         tx_collision,
  output logic              tx_defer,
  output logic              medium_busy_flag,
  output logic              tx_done,
  output logic              collision_tally_msb,
  output logic [1:0]        collision_tally_mid,
  output logic              collision_tally_lsb
);

  erp_state_t   state;
  logic         rclk_prev;
  logic         rise;
  logic [2:0]   tail;
  logic         sfd_hit;
  logic         bit_take;
  logic [7:0]   shift;
  logic [2:0]   bitcnt;
  logic         byte_done;
  logic [7:0]   next_byte;
  logic [31:0]  crc;
  logic [31:0]  next_crc;
  logic [15:0]  frame_cnt;
  logic [15:0]  stored_cnt;
  logic [2:0]   dfill;
  logic [7:0]   dline [ERP_DELAY_BYTES];
  logic         push;
  logic         fifo_in_ready;
  logic         fifo_empty;
  logic         addr_match;
  logic         addr_bcast;
  logic         addr_multi;
  logic         filt_pass;
  logic         filt_done;
  logic         ovf;
  logic         finish_go;
  logic         err_align;
  logic         err_short;
  logic         err_crc;
  logic         accept;
  logic [7:0]   pkt_count;
  logic [3:0]   tally;
  erp_rx_stat_t stat_set;

  function automatic logic [7:0] erp_addr_byte(input logic [47:0] a, input logic [15:0] i);
    logic [7:0] r;
    r = 8'h00;
    for (int k = 0; k < ERP_ADDR_BYTES; k++) begin
      if (i == 16'(k)) begin
        r = a[8*k +: 8];
      end
    end
    return r;
  endfunction : erp_addr_byte

  // Decoder moves data on the falling edge, so the rising edge sits mid-bit
  assign rise      = rx_clk_rec & ~rclk_prev;
  assign sfd_hit   = (state == ERP_HUNT) && rise && ({tail, rx_line_pos} == ERP_SFD_TAIL);
  assign bit_take  = (state == ERP_DATA) && carrier_present && rise;
  assign byte_done = bit_take && (bitcnt == 3'h7);
  assign next_byte = {rx_line_pos, shift[7:1]};
  assign next_crc  = (crc[0] ^ rx_line_pos) ? ((crc >> 1) ^ ERP_CRC_POLY) : (crc >> 1);

  // Oldest byte leaves the delay line only once four newer bytes are behind it
  assign push = byte_done && (dfill == 3'(ERP_DELAY_BYTES)) && !ovf;

  assign finish_go = (state == ERP_FINISH) && fifo_empty;
  assign err_align = (bitcnt != 3'h0);
  assign err_short = (frame_cnt < ERP_MIN_FRAME);
  assign err_crc   = (crc != ERP_CRC_RESIDUE);
  assign accept    = filt_pass && !ovf &&
                     (!(err_align || err_short || err_crc) || accept_bad);

  assign tx_defer            = carrier_present & ~defer_override;
  assign rx_buf_empty        = (pkt_count == ERP_COUNT_RESET);
  assign collision_tally_msb = tally[3];
  assign collision_tally_mid = tally[2:1];
  assign collision_tally_lsb = tally[0];
  assign rx_irq              = |(rx_status & rx_irq_enable);

  // Receive sequencer
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ERP_IDLE;
    end else begin
      case (state)
        ERP_IDLE: begin
          if (carrier_present && !link_section_off) begin
            state <= ERP_HUNT;
          end
        end
        ERP_HUNT: begin
          if (!carrier_present) begin
            state <= ERP_IDLE;
          end else if (sfd_hit) begin
            state <= ERP_DATA;
          end
        end
        ERP_DATA: begin
          if (!carrier_present) begin
            state <= ERP_FINISH;
          end
        end
        ERP_FINISH: begin
          if (fifo_empty) begin
            state <= ERP_IDLE;
          end
        end
        default: state <= ERP_IDLE;
      endcase
    end
  end

  // Bit sampling, preamble tail and byte assembly
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rclk_prev <= 1'b0;
      tail      <= 3'h0;
      shift     <= 8'h00;
      bitcnt    <= 3'h0;
      crc       <= ERP_CRC_INIT;
      frame_cnt <= 16'h0000;
    end else begin
      rclk_prev <= rx_clk_rec;
      if (state == ERP_HUNT && rise) begin
        tail <= {tail[1:0], rx_line_pos};
      end else if (state == ERP_IDLE) begin
        tail <= 3'h0;
      end
      if (sfd_hit) begin
        bitcnt    <= 3'h0;
        crc       <= ERP_CRC_INIT;
        frame_cnt <= 16'h0000;
        tail      <= 3'h0;
      end else if (bit_take) begin
        shift  <= next_byte;
        bitcnt <= bitcnt + 3'h1;
        crc    <= next_crc;
        if (byte_done) begin
          frame_cnt <= frame_cnt + 16'h0001;
        end
      end
    end
  end

  // Four-byte delay line
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dfill <= 3'h0;
    end else if (sfd_hit) begin
      dfill <= 3'h0;
    end else if (byte_done && dfill != 3'(ERP_DELAY_BYTES)) begin
      dfill <= dfill + 3'h1;
    end
  end

  for (genvar g = 0; g < ERP_DELAY_BYTES; g++) begin : g_dline
    always_ff @(posedge clk_sys) begin
      if (byte_done) begin
        dline[g] <= (g == 0) ? next_byte : dline[(g == 0) ? 0 : g - 1];
      end
    end
  end

  // Destination filter, decided when the sixth address byte completes
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      addr_match <= 1'b0;
      addr_bcast <= 1'b0;
      addr_multi <= 1'b0;
      filt_pass  <= 1'b0;
      filt_done  <= 1'b0;
    end else if (sfd_hit) begin
      addr_match <= 1'b1;
      addr_bcast <= 1'b1;
      addr_multi <= 1'b0;
      filt_pass  <= 1'b0;
      filt_done  <= 1'b0;
    end else if (byte_done && !filt_done) begin
      if (next_byte != erp_addr_byte(station_addr, frame_cnt)) begin
        addr_match <= 1'b0;
      end
      if (next_byte != 8'hff) begin
        addr_bcast <= 1'b0;
      end
      if (frame_cnt == 16'h0000) begin
        addr_multi <= next_byte[0];
      end
      if (frame_cnt == 16'(ERP_ADDR_BYTES - 1)) begin
        filt_done <= 1'b1;
        case (erp_filter_t'({filter_mode_high, filter_mode_low}))
          ERP_AF_STATION: filt_pass <= (addr_match && next_byte == station_addr[47:40]) ||
                                       (addr_bcast && next_byte == 8'hff);
          ERP_AF_HASH:    filt_pass <= (addr_match && next_byte == station_addr[47:40]) ||
                                       (addr_bcast && next_byte == 8'hff) ||
                                       (addr_multi && hash_table[next_crc[5:0]]);
          ERP_AF_MULTI:   filt_pass <= (addr_match && next_byte == station_addr[47:40]) ||
                                       addr_multi;
          ERP_AF_ALL:     filt_pass <= 1'b1;
          default:        filt_pass <= 1'b0;
        endcase
      end
    end
  end

  // Space and FIFO checks; a stalled buffer controller counts as overflow too
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ovf        <= 1'b0;
      stored_cnt <= 16'h0000;
    end else if (sfd_hit) begin
      ovf        <= 1'b0;
      stored_cnt <= 16'h0000;
    end else if (push) begin
      if (!fifo_in_ready || stored_cnt >= free_space) begin
        ovf <= 1'b1;
      end else begin
        stored_cnt <= stored_cnt + 16'h0001;
      end
    end
  end

  erp_fifo #(
    .WIDTH (ERP_FIFO_WIDTH),
    .DEPTH (ERP_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .in_valid  (push && fifo_in_ready && stored_cnt < free_space),
    .in_ready  (fifo_in_ready),
    .in_data   (dline[ERP_DELAY_BYTES-1]),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );

  assign fifo_empty = ~out_valid;

  // End-of-frame verdict, issued only after the FIFO has drained
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pkt_commit  <= 1'b0;
      pkt_discard <= 1'b0;
      pkt_header  <= ERP_HDR_RESET;
    end else begin
      pkt_commit  <= finish_go && accept;
      pkt_discard <= finish_go && !accept;
      if (finish_go && accept) begin
        pkt_header.length                 <= stored_cnt;
        pkt_header.status                 <= 8'h00;
        pkt_header.status[ERP_HS_CRC]     <= err_crc;
        pkt_header.status[ERP_HS_ALIGN]   <= err_align;
        pkt_header.status[ERP_HS_SHORT]   <= err_short;
        pkt_header.status[ERP_HS_GOOD]    <= !(err_crc || err_align || err_short);
      end
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle
  always_comb begin
    stat_set             = ERP_STAT_RESET;
    stat_set.pkt_arrived = finish_go && accept;
    stat_set.bus_rd_err  = host_rd && rx_buf_empty;
    stat_set.overflow    = finish_go && filt_pass && ovf;
    stat_set.crc_err     = finish_go && err_crc;
    stat_set.align_err   = finish_go && err_align;
    stat_set.short_err   = finish_go && err_short;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rx_status <= ERP_STAT_RESET;
    end else begin
      rx_status <= (rx_status & ~rx_status_clr) | stat_set;
    end
  end

  // Stored-packet count drives the buffer-empty flag
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pkt_count <= ERP_COUNT_RESET;
    end else begin
      case ({finish_go && accept, host_release && !rx_buf_empty})
        2'b10:   pkt_count <= pkt_count + 8'h01;
        2'b01:   pkt_count <= pkt_count - 8'h01;
        default: pkt_count <= pkt_count;
      endcase
    end
  end

  // Transmit-side statistics
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      medium_busy_flag <= 1'b0;
      tx_done          <= 1'b0;
      tally            <= ERP_TALLY_RESET;
    end else begin
      medium_busy_flag <= carrier_present;
      if (tx_finish) begin
        tx_done <= 1'b1;
      end else if (tx_start) begin
        tx_done <= 1'b0;
      end
      if (tx_start) begin
        tally <= ERP_TALLY_RESET;
      end else if (tx_collision) begin
        tally <= tally + 4'h1;
      end
    end
  end

endmodule : erp_receive_path

// ---- shared/erp_pkg.sv ----
// Constants and carrier types shared by the Ethernet receive path
package erp_pkg;

  // Framing and buffering
  localparam int unsigned ERP_DELAY_BYTES = 4;
  localparam int unsigned ERP_FIFO_DEPTH  = 8;
  localparam int unsigned ERP_FIFO_WIDTH  = 8;
  localparam int unsigned ERP_ADDR_BYTES  = 6;
  localparam logic [15:0] ERP_MIN_FRAME   = 16'h0040;
  localparam logic [3:0]  ERP_SFD_TAIL    = 4'hb;

  // Frame check sequence, reflected form, no final inversion
  localparam logic [31:0] ERP_CRC_POLY    = 32'hedb88320;
  localparam logic [31:0] ERP_CRC_INIT    = 32'hffffffff;
  localparam logic [31:0] ERP_CRC_RESIDUE = 32'hdebb20e3;

  // Header status byte field positions
  localparam int unsigned ERP_HS_OVF   = 1;
  localparam int unsigned ERP_HS_CRC   = 2;
  localparam int unsigned ERP_HS_ALIGN = 3;
  localparam int unsigned ERP_HS_SHORT = 4;
  localparam int unsigned ERP_HS_GOOD  = 5;

  // Reset values
  localparam logic [3:0]  ERP_TALLY_RESET = 4'h0;
  localparam logic [7:0]  ERP_COUNT_RESET = 8'h00;

  typedef enum logic [1:0] {
    ERP_AF_STATION = 2'h0,
    ERP_AF_HASH    = 2'h1,
    ERP_AF_MULTI   = 2'h2,
    ERP_AF_ALL     = 2'h3
  } erp_filter_t;

  typedef enum logic [1:0] {
    ERP_IDLE   = 2'b00,
    ERP_HUNT   = 2'b01,
    ERP_DATA   = 2'b11,
    ERP_FINISH = 2'b10
  } erp_state_t;

  typedef struct packed {
    logic pkt_arrived;
    logic bus_rd_err;
    logic short_err;
    logic align_err;
    logic crc_err;
    logic overflow;
  } erp_rx_stat_t;

  localparam erp_rx_stat_t ERP_STAT_RESET = '0;

  typedef struct packed {
    logic [7:0]  status;
    logic [15:0] length;
  } erp_hdr_t;

  localparam erp_hdr_t ERP_HDR_RESET = '0;

endpackage : erp_pkg

// ---- sim/erp_receive_path_chk.sv ----
// Port-level assertions for the Ethernet receive path
`timescale 1ns/1ps
module erp_receive_path_chk
  import erp_pkg::*;
(
  // Clock and reset
  input wire logic         clk_sys,
  input wire logic         sys_rst,
  // Watched ports
  input wire logic         carrier_present,
  input wire logic         defer_override,
  input wire logic         out_valid,
  input wire logic         out_ready,
  input wire logic [7:0]   out_data,
  input wire logic         pkt_commit,
  input wire logic         pkt_discard,
  input wire logic         host_rd,
  input wire logic         rx_buf_empty,
  input wire erp_rx_stat_t rx_status,
  input wire erp_rx_stat_t rx_irq_enable,
  input wire logic         rx_irq,
  input wire logic         tx_start,
  input wire logic         tx_finish,
  input wire logic         tx_collision,
  input wire logic         tx_defer,
  input wire logic         medium_busy_flag,
  input wire logic         tx_done,
  input wire logic         collision_tally_msb,
  input wire logic [1:0]   collision_tally_mid,
  input wire logic         collision_tally_lsb
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [3:0] tally;
  assign tally = {collision_tally_msb, collision_tally_mid, collision_tally_lsb};

  property p_defer; tx_defer == (carrier_present && !defer_override); endproperty
  property p_busy; !$past(sys_rst) |-> medium_busy_flag == $past(carrier_present); endproperty
  property p_done; tx_finish |=> tx_done; endproperty
  property p_tally_clr; tx_start |=> tally == 4'h0; endproperty
  property p_tally_inc; tx_collision && !tx_start |=> tally == $past(tally) + 4'h1; endproperty
  property p_rd_err; host_rd && rx_buf_empty |=> rx_status.bus_rd_err; endproperty
  property p_irq; rx_irq == |(rx_status & rx_irq_enable); endproperty
  property p_store; pkt_commit |-> ##[0:1] (!rx_buf_empty && rx_status.pkt_arrived); endproperty
  property p_verdict;
    (pkt_commit || pkt_discard) |-> !(pkt_commit && pkt_discard) ##1 !(pkt_commit || pkt_discard);
  endproperty
  property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_data); endproperty

  a_defer: assert property (p_defer)
    else $error("defer output disagrees with carrier");
  a_busy: assert property (p_busy)
    else $error("medium busy flag does not follow carrier");
  a_done: assert property (p_done)
    else $error("transmit done not set after finish");
  a_tally_clr: assert property (p_tally_clr)
    else $error("collision tally not cleared at start");
  a_tally_inc: assert property (p_tally_inc)
    else $error("collision tally did not step by one");
  a_rd_err: assert property (p_rd_err)
    else $error("read of empty buffer not flagged");
  a_irq: assert property (p_irq)
    else $error("interrupt disagrees with masked status");
  a_store: assert property (p_store)
    else $error("stored frame did not update empty and arrived flags");
  a_verdict: assert property (p_verdict)
    else $error("frame verdict not a single clean pulse");
  a_hold: assert property (p_hold)
    else $error("queued byte lost while stalled");

  c_commit: cover property (pkt_commit);
  c_discard: cover property (pkt_discard);
  c_wrap: cover property (tally == 4'hf && tx_collision);
  c_ovf: cover property ($rose(rx_status.overflow));
endmodule : erp_receive_path_chk

bind erp_receive_path erp_receive_path_chk i_chk (.*);

// ---- sim/erp_net_model.sv ----
// Network side model: recovered clock, NRZ data and carrier sense
`timescale 1ns/1ps
module erp_net_model (
  // Pacing clock
  input wire logic clk_sys,
  // Decoder outputs
  output logic     rx_clk_rec,
  output logic     rx_line_pos,
  output logic     carrier_present
);
  logic [7:0] mem [0:127];

  initial begin
    rx_clk_rec = 1'b0;
    rx_line_pos = 1'b0;
    carrier_present = 1'b0;
  end

  // Four system clocks per bit cell, two per clock phase
  task automatic bit_out(input logic b);
    rx_clk_rec = 1'b0;
    rx_line_pos = b;
    repeat (2) @(negedge clk_sys);
    rx_clk_rec = 1'b1;
    repeat (2) @(negedge clk_sys);
  endtask : bit_out

  task automatic send(input int n, input int tail);
    carrier_present = 1'b1;
    for (int i = 0; i < 62; i++) bit_out(~i[0]);
    bit_out(1'b1);
    bit_out(1'b1);
    for (int i = 0; i < n; i++)
      for (int j = 0; j < 8; j++) bit_out(mem[i][j]);
    for (int i = 0; i < tail; i++) bit_out(1'b1);
    // Clock stops and the line shows no stale value once the frame ends
    rx_clk_rec = 1'b0;
    rx_line_pos = ~rx_line_pos;
    carrier_present = 1'b0;
    @(negedge clk_sys);
  endtask : send
endmodule : erp_net_model

// ---- sim/erp_receive_path_test.sv ----
// Self-checking bench for the Ethernet receive path
`timescale 1ns/1ps
module erp_receive_path_test;
  import erp_pkg::*;
  localparam logic [47:0] STA = 48'h0a0b0c0d0e02;
  localparam logic [47:0] MCA = 48'h665544332211;
  localparam logic [47:0] OTH = 48'h665544332210;
  // Bench-driven inputs
  logic         clk_sys, sys_rst, link_section_off, filter_mode_high, filter_mode_low;
  logic         accept_bad, defer_override, out_ready, host_rd, host_release;
  logic         tx_start, tx_finish, tx_collision;
  logic [15:0]  free_space;
  logic [47:0]  station_addr;
  logic [63:0]  hash_table;
  erp_rx_stat_t rx_status_clr, rx_irq_enable;
  // Model and design outputs
  logic         rx_clk_rec, rx_line_pos, carrier_present, out_valid, pkt_commit;
  logic         pkt_discard, rx_buf_empty, rx_irq, tx_defer, medium_busy_flag, tx_done;
  logic         collision_tally_msb, collision_tally_lsb;
  logic [1:0]   collision_tally_mid;
  logic [7:0]   out_data;
  erp_hdr_t     pkt_header;
  erp_rx_stat_t rx_status;
  logic [7:0]   got [$];
  int           err_total, n_compared, cyc, n_verdict;

  erp_net_model i_net (.*);
  erp_receive_path i_dut (.*);

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (out_valid && out_ready) got.push_back(out_data);
    if (pkt_commit || pkt_discard) n_verdict++;
    if (cyc == 60000) begin
      err_total++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
    @(negedge clk_sys);
  endtask : pulse

  // Fills the model's frame memory and appends the check sequence
  task automatic build(input logic [47:0] da, input int nd);
    logic [31:0] c;
    c = ERP_CRC_INIT;
    for (int i = 0; i < nd; i++) begin
      // Bytes 12 and 13 form a type code above 1500, so no length check is due
      i_net.mem[i] = (i < 6) ? da[8*i +: 8] : 8'(i * 3);
      for (int j = 0; j < 8; j++)
        c = (c >> 1) ^ ((c[0] ^ i_net.mem[i][j]) ? ERP_CRC_POLY : 32'h0);
    end
    for (int k = 0; k < 4; k++) i_net.mem[nd + k] = ~c[8*k +: 8];
  endtask : build

  task automatic verdict(input logic c, input erp_rx_stat_t st, input erp_rx_stat_t m);
    int w;
    w = 0;
    while (pkt_commit !== 1'b1 && pkt_discard !== 1'b1 && w < 400) begin
      @(negedge clk_sys);
      w++;
    end
    check(pkt_commit, c);
    check(pkt_discard, !c);
    check(rx_status & m, st);
    check(rx_irq, |(st & rx_irq_enable));
    check(rx_buf_empty, !c);
    host_release = c;
    rx_status_clr = '1;
    @(negedge clk_sys);
    rx_status_clr = '0;
    host_release = 1'b0;
    check(rx_irq, 1'b0);
    check(rx_buf_empty, 1'b1);
  endtask : verdict

  task automatic run(input int n, input int tail, input logic c, input erp_rx_stat_t st,
                     input erp_rx_stat_t m);
    got.delete();
    i_net.send(n, tail);
    verdict(c, st, m);
  endtask : run

  task automatic t_host;
    check(rx_buf_empty, 1'b1);
    pulse(host_release);
    check(rx_buf_empty, 1'b1);
    pulse(host_rd);
    check(rx_status, 6'h10);
    check(rx_irq, 1'b0);
    rx_status_clr = 6'h10;
    @(negedge clk_sys);
    rx_status_clr = '0;
    check(rx_status, 6'h00);
    check(rx_buf_empty, 1'b1);
  endtask : t_host

  task automatic t_good;
    build(STA, 60);
    run(64, 0, 1'b1, 6'h20, '1);
    check(got.size(), 60);
    for (int i = 0; i < 60; i++) check(got[i], i_net.mem[i]);
    check(pkt_header, {8'h20, 16'h003c});
  endtask : t_good

  task automatic t_errors;
    rx_irq_enable = 6'h0f;
    build(STA, 60);
    i_net.mem[60] ^= 8'h01;
    run(64, 0, 1'b0, 6'h02, '1);
    build(STA, 40);
    run(44, 0, 1'b0, 6'h08, '1);
    build(STA, 60);
    run(64, 4, 1'b0, 6'h04, 6'h04);
    accept_bad = 1'b1;
    i_net.mem[60] ^= 8'h01;
    run(64, 0, 1'b1, 6'h22, '1);
    check(pkt_header, {8'h04, 16'h003c});
    accept_bad = 1'b0;
    rx_irq_enable = '0;
  endtask : t_errors

  task automatic t_filter;
    build(MCA, 60);
    for (int m = 0; m < 4; m++) begin
      {filter_mode_high, filter_mode_low} = 2'(m);
      run(64, 0, m != 0, (m != 0) ? 6'h20 : 6'h00, '1);
    end
    // An empty hash table must turn the same multicast frame away
    {filter_mode_high, filter_mode_low} = 2'h1;
    hash_table = '0;
    run(64, 0, 1'b0, 6'h00, '1);
    hash_table = '1;
    {filter_mode_high, filter_mode_low} = 2'h0;
    build(OTH, 60);
    run(64, 0, 1'b0, 6'h00, '1);
  endtask : t_filter

  task automatic t_link_off;
    int v;
    v = n_verdict;
    link_section_off = 1'b1;
    build(STA, 60);
    got.delete();
    i_net.send(64, 0);
    repeat (20) @(negedge clk_sys);
    check(n_verdict - v, 0);
    check(got.size(), 0);
    link_section_off = 1'b0;
  endtask : t_link_off

  task automatic t_space;
    free_space = 16'h000a;
    build(STA, 60);
    run(64, 0, 1'b0, 6'h01, '1);
    free_space = 16'hffff;
    defer_override = 1'b1;
    run(64, 0, 1'b1, 6'h20, '1);
    defer_override = 1'b0;
  endtask : t_space

  // Far side stalls for the whole frame, so the queue fills and refuses
  task automatic t_stall;
    build(STA, 60);
    got.delete();
    out_ready = 1'b0;
    i_net.send(64, 0);
    check(out_valid, 1'b1);
    check(out_data, i_net.mem[0]);
    out_ready = 1'b1;
    verdict(1'b0, 6'h01, '1);
    check(got.size(), 8);
    for (int i = 0; i < 8; i++) check(got[i], i_net.mem[i]);
  endtask : t_stall

  task automatic t_tx;
    pulse(tx_start);
    for (int i = 0; i < 17; i++) pulse(tx_collision);
    check({collision_tally_msb, collision_tally_mid, collision_tally_lsb}, 4'h1);
    pulse(tx_finish);
    check(tx_done, 1'b1);
    pulse(tx_start);
    check({collision_tally_msb, collision_tally_mid, collision_tally_lsb}, 4'h0);
    check(tx_done, 1'b0);
  endtask : t_tx

  task final_report;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  initial begin
    {sys_rst, link_section_off, filter_mode_high, filter_mode_low} = 4'h8;
    {accept_bad, defer_override, out_ready, host_rd, host_release} = 5'h04;
    {tx_start, tx_finish, tx_collision} = 3'h0;
    free_space = 16'hffff;
    station_addr = STA;
    hash_table = '1;
    rx_status_clr = '0;
    rx_irq_enable = '0;
    repeat (6) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_host();
    t_good();
    t_errors();
    t_filter();
    t_link_off();
    t_space();
    t_stall();
    t_tx();
    final_report();
  end
endmodule : erp_receive_path_test
